// >>> pkg/snv_consts.vh
// Purpose: Shared constants of the serial nonvolatile memory slave
// Assumes: Included by bare name from the logic files
// Notes:   Definitions only
`ifndef SNV_CONSTS_VH
`define SNV_CONSTS_VH

// Opcodes
`define SNV_OP_SET_LATCH    8'h06
`define SNV_OP_CLR_LATCH    8'h04
`define SNV_OP_STAT_READ    8'h05
`define SNV_OP_STAT_WRITE   8'h01
`define SNV_OP_MEM_READ     8'h03
`define SNV_OP_MEM_WRITE    8'h02

// Status byte layout
`define SNV_ST_PROT_EN      7
`define SNV_ST_SPARE_HI     6
`define SNV_ST_SPARE_LO     4
`define SNV_ST_BP_HI        3
`define SNV_ST_BP_LO        2
`define SNV_ST_LATCH        1
`define SNV_ST_ZERO         0
`define SNV_STATUS_RST      6'h00

// Block protect codes and bases
`define SNV_BP_NONE         2'h0
`define SNV_BP_QUARTER      2'h1
`define SNV_BP_HALF         2'h2
`define SNV_BP_ALL          2'h3
`define SNV_BASE_QUARTER    15'h6000
`define SNV_BASE_HALF       15'h4000

// Widths and counts
`define SNV_AW              15
`define SNV_DW              8
`define SNV_BIT_LAST        3'h7
`define SNV_OPC_LAST        4'h7
`define SNV_ADDR_LAST       4'hf
`define SNV_FIFO_DEPTH      32
`define SNV_FIFO_AW         5
`define SNV_PIN_CNT         5

`endif

// >>> logic/snv_sync.v
// Purpose: Two flip-flop synchroniser for a group of pin levels
// Assumes: Each bit is an independent level
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module snv_sync #(
  parameter W       = 1,
  parameter RST_VAL = 1'b0
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{RST_VAL}};
      dout     <= {W{RST_VAL}};
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule // snv_sync

// >>> logic/snv_fifo.v
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two, AW its log2
// Notes:   Full and empty are exact
`timescale 1ns/1ps
module snv_fifo #(
  parameter W     = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0]  mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0]   count_reg;
  wire         push;
  wire         pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // snv_fifo

// >>> logic/snv_slave.v
// Purpose: Serial slave front end of a 32K x 8 nonvolatile memory
// Assumes: Serial clock at most an eighth of CLOCK; array read has one cycle latency
// Notes:   Array itself sits outside; writes leave through a 32-word FIFO
`timescale 1ns/1ps
`include "snv_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - First byte after select is an opcode; unknown opcodes are ignored
// - Opcodes 06 set, 04 clear latch, 05/01 status, 03/02 memory
// - Select rising before eight opcode bits means no command runs
// - Set-latch opcode sets the write latch, needed before any write
// - Clear-latch opcode clears it; cleared latch blocks all writes
// - Status read shifts eight status bits out on falling edges
// - Status read repeats while clocking continues with select low
// - Status write takes one data byte into the status bits
// - Latch and lowest bit positions ignored on write; lowest reads zero
// - Memory read takes 16-bit address, top bit ignored, then outputs
// - Every further eight clocks read the next address
// - Sequential read wraps from top address to zero
// - Memory write commits each byte once all eight bits arrive
// - Further bytes go to incremented addresses until select rises
// - Sequential write wraps from top address to zero
// - Block-protect bits select none, upper quarter, upper half, all
// - Protected blocks never written; others need the latch set
// - Status write blocked if latch clear or protect-enable with pin low
// - Hold low with select low pauses command, clock and data ignored
// - Hold begins and ends at a low serial clock level
// - Data output floats while held
// - Select rising while held aborts and returns to idle
// - Input sampled on rising clock, output changed on falling clock
// - Write latch cleared at reset, by clear, and on decoding a status or memory write opcode
// - Status: protect-enable 7, spare 6..4, block bits 3..2, latch 1, zero 0
// - Select high: inputs ignored, output floats, slave idle
module snv_slave (
  CLOCK,
  RST_N,
  CS_N,
  SCK,
  SI,
  HOLD_N,
  WP_N,
  SO,
  SO_OE,
  MEM_RD_ADDR,
  MEM_RD_DATA,
  MEM_WR_VALID,
  MEM_WR_ADDR,
  MEM_WR_DATA,
  MEM_WR_READY,
  WR_BUF_FULL,
  STATUS_BYTE
);
  input                     CLOCK;
  input                     RST_N;
  input                     CS_N;
  input                     SCK;
  input                     SI;
  input                     HOLD_N;
  input                     WP_N;
  output reg                SO;
  output reg                SO_OE;
  output reg [`SNV_AW-1:0]  MEM_RD_ADDR;
  input      [`SNV_DW-1:0]  MEM_RD_DATA;
  output reg                MEM_WR_VALID;
  output reg [`SNV_AW-1:0]  MEM_WR_ADDR;
  output reg [`SNV_DW-1:0]  MEM_WR_DATA;
  input                     MEM_WR_READY;
  output reg                WR_BUF_FULL;
  output reg [`SNV_DW-1:0]  STATUS_BYTE;

  localparam [2:0] ST_OPC   = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_RDATA = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_SREAD = 3'h4;
  localparam [2:0] ST_SDATA = 3'h5;
  localparam [2:0] ST_IDLE  = 3'h6;
  localparam [2:0] ST_RADDR = 3'h7;
  localparam       FW       = `SNV_AW + `SNV_DW;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire                    cs_n_s;
  wire                    sck_s;
  wire                    si_s;
  wire                    hold_n_s;
  wire                    wp_n_s;

  snv_sync #(
    .W       (`SNV_PIN_CNT),
    .RST_VAL (1'b1)
  ) u_sync (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .din   ({CS_N, SCK, SI, HOLD_N, WP_N}),
    .dout  ({cs_n_s, sck_s, si_s, hold_n_s, wp_n_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg                   sck_d_reg;
  reg                   hold_reg;
  reg                   hold_next;
  reg [2:0]             state_reg;
  reg [2:0]             state_next;
  reg [3:0]             cnt_reg;
  reg [3:0]             cnt_next;
  reg [`SNV_DW-1:0]     in_reg;
  reg [`SNV_DW-1:0]     in_next;
  reg [`SNV_AW-1:0]     addr_reg;
  reg [`SNV_AW-1:0]     addr_next;
  reg                   latch_reg;
  reg                   latch_next;
  reg                   wr_ok_reg;
  reg                   wr_ok_next;
  reg [5:0]             nv_reg;
  reg [5:0]             nv_next;
  reg [`SNV_DW-1:0]     out_reg;
  reg [`SNV_DW-1:0]     out_next;
  reg                   load_reg;
  reg                   load_next;
  reg                   drive_reg;
  reg                   drive_next;
  reg                   so_next;
  reg [`SNV_AW-1:0]     rd_addr_next;
  reg [`SNV_DW-1:0]     rd_data_reg;
  reg                   push;
  reg [FW-1:0]          push_data;

  wire                  rise;
  wire                  fall;
  wire [`SNV_DW-1:0]    byte_in;
  wire [`SNV_DW-1:0]    status_word;
  wire                  bit_last;
  wire                  prot_hit;
  wire                  stat_ok;
  wire                  fifo_ready;
  wire                  fifo_valid;
  wire [FW-1:0]         fifo_data;
  wire                  fifo_pop;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection, gated by select and hold
  assign rise     = ~cs_n_s & ~hold_reg & sck_s & ~sck_d_reg;
  assign fall     = ~cs_n_s & ~hold_reg & ~sck_s & sck_d_reg;
  assign byte_in  = {in_reg[6:0], si_s};
  assign bit_last = (cnt_reg[2:0] == `SNV_BIT_LAST);

  assign status_word = {nv_reg[5:2], nv_reg[1:0], latch_reg, 1'b0};

  // Block protection of the current write address
  assign prot_hit =
    (nv_reg[1:0] == `SNV_BP_ALL) |
    ((nv_reg[1:0] == `SNV_BP_HALF) & (addr_reg >= `SNV_BASE_HALF)) |
    ((nv_reg[1:0] == `SNV_BP_QUARTER) & (addr_reg >= `SNV_BASE_QUARTER));

  // Status write allowed only with latch seen at opcode and pin policy
  assign stat_ok = wr_ok_reg & ~(nv_reg[5] & ~wp_n_s);

  ////////////////////////////////////////////////////////////////////////////
  // Hold tracking: cleared while deselected, otherwise changes only while the serial clock is low
  always @* begin
    hold_next = hold_reg;
    if (cs_n_s) begin
      hold_next = 1'b0;
    end else if (~sck_s) begin
      hold_next = ~hold_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always @* begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    in_next      = in_reg;
    addr_next    = addr_reg;
    latch_next   = latch_reg;
    wr_ok_next   = wr_ok_reg;
    nv_next      = nv_reg;
    out_next     = out_reg;
    load_next    = load_reg;
    drive_next   = drive_reg;
    so_next      = SO;
    rd_addr_next = MEM_RD_ADDR;
    push         = 1'b0;
    push_data    = {addr_reg, byte_in};
    if (cs_n_s) begin
      state_next = ST_OPC;
      cnt_next   = 4'h0;
      load_next  = 1'b0;
      drive_next = 1'b0;
    end else if (rise) begin
      in_next  = byte_in;
      cnt_next = cnt_reg + 4'h1;
      case (state_reg)
        ST_OPC: begin
          if (cnt_reg == `SNV_OPC_LAST) begin
            cnt_next = 4'h0;
            case (byte_in)
              `SNV_OP_SET_LATCH: begin
                latch_next = 1'b1;
                state_next = ST_IDLE;
              end
              `SNV_OP_CLR_LATCH: begin
                latch_next = 1'b0;
                state_next = ST_IDLE;
              end
              `SNV_OP_STAT_READ: begin
                state_next = ST_SREAD;
                load_next  = 1'b1;
              end
              `SNV_OP_STAT_WRITE: begin
                wr_ok_next = latch_reg;
                latch_next = 1'b0;
                state_next = ST_SDATA;
              end
              `SNV_OP_MEM_READ: begin
                wr_ok_next = 1'b0;
                state_next = ST_RADDR;
              end
              `SNV_OP_MEM_WRITE: begin
                wr_ok_next = latch_reg;
                latch_next = 1'b0;
                state_next = ST_ADDR;
              end
              default: begin
                state_next = ST_IDLE;
              end
            endcase
          end
        end
        ST_ADDR, ST_RADDR: begin
          addr_next = {addr_reg[`SNV_AW-2:0], si_s};
          if (cnt_reg == `SNV_ADDR_LAST) begin
            cnt_next     = 4'h0;
            state_next   = (state_reg == ST_RADDR) ? ST_RDATA : ST_WDATA;
            load_next    = (state_reg == ST_RADDR);
            rd_addr_next = addr_next;
          end
        end
        ST_WDATA: begin
          if (bit_last) begin
            push = wr_ok_reg & ~prot_hit;
            addr_next = addr_reg + {{(`SNV_AW-1){1'b0}}, 1'b1};
          end
        end
        ST_RDATA: begin
          if (bit_last) begin
            addr_next    = addr_reg + {{(`SNV_AW-1){1'b0}}, 1'b1};
            rd_addr_next = addr_next;
            load_next    = 1'b1;
          end
        end
        ST_SREAD: begin
          if (bit_last) begin
            load_next = 1'b1;
          end
        end
        ST_SDATA: begin
          if (bit_last) begin
            if (stat_ok) begin
              nv_next = byte_in[7:2];
            end
            state_next = ST_IDLE;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end else if (fall) begin
      if (load_reg) begin
        out_next   = (state_reg == ST_SREAD) ? status_word : rd_data_reg;
        so_next    = out_next[7];
        load_next  = 1'b0;
        drive_next = 1'b1;
      end else begin
        out_next = {out_reg[6:0], 1'b0};
        so_next  = out_reg[6];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sck_d_reg   <= 1'b1;
      hold_reg    <= 1'b0;
      state_reg   <= ST_OPC;
      cnt_reg     <= 4'h0;
      in_reg      <= 8'h00;
      addr_reg    <= 15'h0000;
      latch_reg   <= 1'b0;
      wr_ok_reg   <= 1'b0;
      nv_reg      <= `SNV_STATUS_RST;
      out_reg     <= 8'h00;
      load_reg    <= 1'b0;
      drive_reg   <= 1'b0;
      SO          <= 1'b0;
      SO_OE       <= 1'b0;
      MEM_RD_ADDR <= 15'h0000;
      rd_data_reg <= 8'h00;
      STATUS_BYTE <= 8'h00;
    end else begin
      sck_d_reg   <= sck_s;
      hold_reg    <= hold_next;
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      in_reg      <= in_next;
      addr_reg    <= addr_next;
      latch_reg   <= latch_next;
      wr_ok_reg   <= wr_ok_next;
      nv_reg      <= nv_next;
      out_reg     <= out_next;
      load_reg    <= load_next;
      drive_reg   <= drive_next;
      SO          <= so_next;
      SO_OE       <= drive_next & ~hold_next & ~cs_n_s;
      MEM_RD_ADDR <= rd_addr_next;
      rd_data_reg <= MEM_RD_DATA;
      STATUS_BYTE <= status_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write buffer and array write port
  snv_fifo #(
    .W     (FW),
    .DEPTH (`SNV_FIFO_DEPTH),
    .AW    (`SNV_FIFO_AW)
  ) u_fifo (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (push_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  assign fifo_pop = fifo_valid & (~MEM_WR_VALID | MEM_WR_READY);

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      MEM_WR_VALID <= 1'b0;
      MEM_WR_ADDR  <= 15'h0000;
      MEM_WR_DATA  <= 8'h00;
      WR_BUF_FULL  <= 1'b0;
    end else begin
      WR_BUF_FULL <= ~fifo_ready;
      if (fifo_pop) begin
        MEM_WR_VALID <= 1'b1;
        MEM_WR_ADDR  <= fifo_data[FW-1:`SNV_DW];
        MEM_WR_DATA  <= fifo_data[`SNV_DW-1:0];
      end else if (MEM_WR_READY) begin
        MEM_WR_VALID <= 1'b0;
      end
    end
  end
endmodule // snv_slave

// >>> verification/snv_slave_monitor.sv
// Purpose: Port checker of the serial memory slave
// Assumes: Serial clock half period of four CLOCK or more
// Notes:   Bound to snv_slave after the module
`timescale 1ns/1ps
`include "snv_consts.vh"
module snv_slave_monitor (
  input wire               CLOCK,
  input wire               RST_N,
  input wire               CS_N,
  input wire               SCK,
  input wire               HOLD_N,
  input wire               SO,
  input wire               SO_OE,
  input wire               MEM_WR_VALID,
  input wire [`SNV_AW-1:0] MEM_WR_ADDR,
  input wire [`SNV_DW-1:0] MEM_WR_DATA,
  input wire               MEM_WR_READY,
  input wire               WR_BUF_FULL,
  input wire [`SNV_DW-1:0] STATUS_BYTE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  AST_OE_IDLE: assert property (CS_N [*8] |-> !SO_OE)
    else $error("Output enabled while deselected");
  AST_STAT_ZERO: assert property (STATUS_BYTE[`SNV_ST_ZERO] == 1'b0)
    else $error("Lowest status bit not zero");
  AST_HOLD_FLOAT: assert property ($fell(HOLD_N) && !SCK && !CS_N ##1 (!HOLD_N && !SCK) [*3]
    |-> ##[1:4] !SO_OE)
    else $error("Output driven while held");
  AST_WR_STALL: assert property (MEM_WR_VALID && !MEM_WR_READY
    |=> MEM_WR_VALID && $stable(MEM_WR_ADDR) && $stable(MEM_WR_DATA))
    else $error("Array write request changed before accept");
  AST_LATCH_SEL: assert property ($rose(STATUS_BYTE[`SNV_ST_LATCH]) |-> !$past(CS_N, 3))
    else $error("Latch set without select");
  AST_PROT_ALL: assert property (MEM_WR_VALID |-> STATUS_BYTE[3:2] != `SNV_BP_ALL)
    else $error("Write issued with whole array protected");
  AST_FULL_KEEP: assert property (WR_BUF_FULL && !$past(MEM_WR_READY) |=> WR_BUF_FULL)
    else $error("Full flag dropped without a pop");
  AST_DRAIN: assert property (WR_BUF_FULL && MEM_WR_VALID && MEM_WR_READY |-> ##[1:2] !WR_BUF_FULL)
    else $error("Full flag stuck after a pop");
  AST_SO_FALL: assert property ($changed(SO) && SO_OE && $past(SO_OE) |-> !$past(SCK, 2))
    else $error("Output changed away from falling clock");

  cover property (MEM_WR_VALID && MEM_WR_READY);
  cover property ($rose(WR_BUF_FULL));
  cover property ($rose(SO_OE));
endmodule // snv_slave_monitor

bind snv_slave snv_slave_monitor mon (.CLOCK(CLOCK), .RST_N(RST_N), .CS_N(CS_N), .SCK(SCK), .HOLD_N(HOLD_N),
  .SO(SO), .SO_OE(SO_OE), .MEM_WR_VALID(MEM_WR_VALID), .MEM_WR_ADDR(MEM_WR_ADDR), .MEM_WR_DATA(MEM_WR_DATA),
  .MEM_WR_READY(MEM_WR_READY), .WR_BUF_FULL(WR_BUF_FULL), .STATUS_BYTE(STATUS_BYTE));

// >>> verification/snv_host_model.sv
// Purpose: Serial bus host driving the slave pins
// Assumes: Mode 0, serial clock of eight CLOCK periods
// Notes:   Clock stands low between frames
`timescale 1ns/1ps
module snv_host_model (
  input  wire  CLOCK,
  input  wire  SO,
  input  wire  SO_OE,
  output logic CS_N   = 1'b1,
  output logic SCK    = 1'b0,
  output logic SI     = 1'b0,
  output logic HOLD_N = 1'b1
);
  task automatic tick(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  task automatic start();
    CS_N = 1'b0;
    tick(4);
  endtask
  task automatic stop();
    SCK = 1'b0;
    tick(4);
    CS_N = 1'b1;
    SI = ~SI;
    tick(8);
  endtask
  // Floating output read as the inverse of its level
  task automatic xbits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      SCK = 1'b0;
      SI = tx[i];
      tick(4);
      rx[i] = SO_OE ? SO : ~SO;
      SCK = 1'b1;
      tick(4);
    end
  endtask
  // Clock keeps toggling while held
  task automatic hold_on();
    SCK = 1'b0;
    tick(4);
    HOLD_N = 1'b0;
    tick(8);
    repeat (2) begin
      SCK = 1'b1;
      SI = ~SI;
      tick(4);
      SCK = 1'b0;
      tick(4);
    end
  endtask
  task automatic hold_off();
    HOLD_N = 1'b1;
    tick(4);
  endtask
endmodule // snv_host_model

// >>> verification/snv_slave_bench.sv
// Purpose: Self-checking bench of the serial memory slave
// Assumes: Array modelled here with one cycle read latency
// Notes:   Random data from a fixed xorshift seed
`timescale 1ns/1ps
`include "snv_consts.vh"
module snv_slave_bench;
  logic CLOCK = 0, RST_N = 0, WP_N = 1, rdy = 1, stall = 0;
  wire CS_N, SCK, SI, HOLD_N, SO, SO_OE, MEM_WR_VALID, WR_BUF_FULL;
  wire [14:0] MEM_RD_ADDR, MEM_WR_ADDR;
  wire [7:0] MEM_WR_DATA, STATUS_BYTE;
  logic [7:0] rd = 0, rx;
  logic [22:0] wq[$], eq[$];
  logic [15:0] base [4] = '{16'hFFFF, 16'h5FFF, 16'h3FFF, 16'h1234};
  logic [31:0] seed = 32'h0000_ed79;
  int fails = 0, total_checks = 0, cyc = 0;

  always #25 CLOCK = ~CLOCK;
  snv_slave uut (.CLOCK(CLOCK), .RST_N(RST_N), .CS_N(CS_N), .SCK(SCK), .SI(SI), .HOLD_N(HOLD_N), .WP_N(WP_N),
    .SO(SO), .SO_OE(SO_OE), .MEM_RD_ADDR(MEM_RD_ADDR), .MEM_RD_DATA(rd), .MEM_WR_VALID(MEM_WR_VALID),
    .MEM_WR_ADDR(MEM_WR_ADDR), .MEM_WR_DATA(MEM_WR_DATA), .MEM_WR_READY(rdy), .WR_BUF_FULL(WR_BUF_FULL),
    .STATUS_BYTE(STATUS_BYTE));
  snv_host_model host (.CLOCK(CLOCK), .SO(SO), .SO_OE(SO_OE), .CS_N(CS_N), .SCK(SCK), .SI(SI), .HOLD_N(HOLD_N));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] pat(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]};
  endfunction
  function automatic logic prot(input logic [1:0] bp, input logic [14:0] a);
    return bp == 2'h3 || (bp == 2'h2 && a >= 15'h4000) || (bp == 2'h1 && a >= 15'h6000);
  endfunction

  always @(posedge CLOCK) begin
    rd <= pat(MEM_RD_ADDR);
    if (MEM_WR_VALID === 1'b1 && rdy) wq.push_back({MEM_WR_ADDR, MEM_WR_DATA});
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      summarize();
    end
  end
  always @(negedge CLOCK) rdy <= !stall && (rnd() % 4 != 0);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op);
    host.start();
    host.xbits(op, 8, rx);
    host.stop();
  endtask
  task automatic status_write(input logic [7:0] v);
    host.start();
    host.xbits(`SNV_OP_STAT_WRITE, 8, rx);
    host.xbits(v, 8, rx);
    host.stop();
  endtask
  task automatic wmem(input logic [15:0] a, input int n, input logic [1:0] bp, input logic write_enable_latch);
    logic [7:0] d;
    host.start();
    host.xbits(`SNV_OP_MEM_WRITE, 8, rx);
    host.xbits(a[15:8], 8, rx);
    host.xbits(a[7:0], 8, rx);
    for (int i = 0; i < n; i++) begin
      d = 8'(rnd());
      host.xbits(d, 8, rx);
      // Buffer holds its depth plus the word waiting at the array port
      if (write_enable_latch && !prot(bp, a[14:0]) && eq.size() <= `SNV_FIFO_DEPTH) eq.push_back({a[14:0], d});
      a[14:0] = a[14:0] + 15'h1;
    end
    host.stop();
  endtask
  task automatic drain();
    for (int i = 0; i < 3000 && wq.size() < eq.size(); i++) @(negedge CLOCK);
    repeat (100) @(negedge CLOCK);
    chk("write_count", wq.size(), eq.size());
    foreach (eq[i]) chk("write", wq.size() > i ? wq[i] : 23'h0, eq[i]);
    wq.delete();
    eq.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge CLOCK);
    RST_N = 1;
    repeat (8) @(negedge CLOCK);
    chk("status", STATUS_BYTE, 0);
    chk("so_oe", SO_OE, 0);
    cmd(`SNV_OP_SET_LATCH);
    chk("latch", STATUS_BYTE, 8'h02);
    cmd(`SNV_OP_CLR_LATCH);
    chk("latch", STATUS_BYTE, 0);
    host.start();
    host.xbits(`SNV_OP_SET_LATCH, 7, rx);
    host.stop();
    chk("partial", STATUS_BYTE, 0);
    for (int i = 0; i < 8; i++) begin
      rx = 8'(rnd()) | 8'h08;
      cmd(rx);
      chk("unknown", STATUS_BYTE, 0);
    end
    status_write(8'hFF);
    chk("status_write_nolatch", STATUS_BYTE, 0);
    cmd(`SNV_OP_SET_LATCH);
    status_write(8'hFF);
    chk("status_write", STATUS_BYTE, 8'hFC);
    host.start();
    host.xbits(`SNV_OP_STAT_READ, 8, rx);
    repeat (2) begin
      host.xbits(8'(rnd()), 8, rx);
      chk("status_read", rx, 8'hFC);
    end
    host.stop();
    WP_N = 0;
    cmd(`SNV_OP_SET_LATCH);
    status_write(8'h00);
    chk("status_write_wp", STATUS_BYTE, 8'hFC);
    WP_N = 1;
    cmd(`SNV_OP_SET_LATCH);
    status_write(8'h00);
    chk("status_write_wp", STATUS_BYTE, 0);
    host.start();
    host.xbits(`SNV_OP_MEM_READ, 8, rx);
    host.xbits(8'hFF, 8, rx);
    host.xbits(8'hFE, 8, rx);
    for (int i = 0; i < 3; i++) begin
      host.xbits(8'(rnd()), 8, rx);
      chk("read", rx, pat(15'(32'h7FFE + i)));
      if (i == 0) begin
        host.hold_on();
        chk("hold_oe", SO_OE, 0);
        host.hold_off();
      end
    end
    host.stop();
    for (int bp = 0; bp < 4; bp++) begin
      cmd(`SNV_OP_SET_LATCH);
      status_write({4'h0, 2'(bp), 2'h0});
      chk("bp", STATUS_BYTE, {4'h0, 2'(bp), 2'h0});
      cmd(`SNV_OP_SET_LATCH);
      wmem(base[bp], 2, 2'(bp), 1'b1);
      drain();
    end
    cmd(`SNV_OP_SET_LATCH);
    status_write(8'h00);
    wmem(16'h0100, 2, 2'h0, 1'b0);
    drain();
    stall = 1;
    cmd(`SNV_OP_SET_LATCH);
    wmem(16'(rnd()), 34, 2'h0, 1'b1);
    chk("full", WR_BUF_FULL, 1);
    stall = 0;
    drain();
    chk("full", WR_BUF_FULL, 0);
    host.start();
    host.xbits(`SNV_OP_SET_LATCH, 4, rx);
    host.hold_on();
    host.stop();
    host.hold_off();
    cmd(`SNV_OP_SET_LATCH);
    chk("abort", STATUS_BYTE, 8'h02);
    summarize();
  end
endmodule // snv_slave_bench
